// ### tca_pkg.sv
// Package: constants, types and register map of the temperature conversion core
package tca_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam real CLK_FREQ_KHZ    = 50000.0;  // System clock, 50 MHz
    localparam real PWRUP_TIME_MS   = 1.5;      // Power-up wait before any conversion
    localparam real CONV_TIME_MS    = 15.5;     // One conversion, typical
    localparam real CYCLE_TIME_MS   = 1000.0;   // Conversion cycle period
    localparam real TIMEOUT_MIN_MS  = 20.0;     // Bus timeout window, lower bound
    localparam real TIMEOUT_MAX_MS  = 40.0;     // Bus timeout window, upper bound
    localparam real TIMEOUT_MS      = (TIMEOUT_MIN_MS + TIMEOUT_MAX_MS) / 2.0;

    localparam int PWRUP_CYC   = int'($ceil(PWRUP_TIME_MS * CLK_FREQ_KHZ));
    localparam int CONV_CYC    = int'(CONV_TIME_MS * CLK_FREQ_KHZ);
    localparam int CYCLE_CYC   = int'(CYCLE_TIME_MS * CLK_FREQ_KHZ);
    localparam int TIMEOUT_CYC = int'($ceil(TIMEOUT_MS * CLK_FREQ_KHZ));

    // ------------------------------------------------------------
    // Averaging
    // ------------------------------------------------------------
    localparam logic [2:0] AVG_LAST_EIGHT = 3'h7;  // Index of the eighth sample
    localparam logic [2:0] AVG_LAST_ONE   = 3'h0;  // Index of the only sample

    // ------------------------------------------------------------
    // Register map (byte offsets) and values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_RESULT = 8'h00;
    localparam logic [7:0] OFF_UPPER  = 8'h04;
    localparam logic [7:0] OFF_LOWER  = 8'h08;
    localparam logic [7:0] OFF_CONFIG = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_CLEAR  = 8'h14;
    localparam logic [7:0] OFF_ENABLE = 8'h18;
    localparam logic [7:0] OFF_LINK   = 8'h1c;

    localparam logic [15:0] RESULT_RESET = 16'h8000;  // Most negative code
    localparam logic [15:0] UPPER_RESET  = 16'h7fff;
    localparam logic [15:0] LOWER_RESET  = 16'h8000;
    localparam logic [2:0]  HSIZE_WORD   = 3'h2;

    // Field values
    localparam logic [1:0] MODE_CONT     = 2'h0;
    localparam logic [1:0] MODE_SHUTDOWN = 2'h1;
    localparam logic [1:0] MODE_SINGLE   = 2'h3;
    localparam logic [1:0] AVG_EIGHT     = 2'h1;

    // Status / clear / enable bit positions
    localparam int ST_READY   = 0;
    localparam int ST_HIGH    = 1;
    localparam int ST_LOW     = 2;
    localparam int ST_TIMEOUT = 3;
    localparam int ST_W       = 4;
    localparam logic [ST_W-1:0] STATUS_RESET = 4'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] averaging_select;
        logic [1:0] conversion_mode_select;
    } tca_cfg_s;

    localparam tca_cfg_s CFG_RESET = '{averaging_select: AVG_EIGHT,
                                       conversion_mode_select: MODE_SHUTDOWN};

    typedef enum logic [1:0] {
        TCA_POWERUP    = 2'h0,
        TCA_CONVERT    = 2'h1,
        TCA_STANDBY    = 2'h3,
        TCA_POWER_DOWN = 2'h2
    } tca_state_e;

endpackage

// ### tca_sync.sv
// Two flip-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ns
module tca_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;  // First stage, read only by the second

    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule // tca_sync

// ### tca_link_watch.sv
// Serial bus watcher: start/stop tracking, clock-stall timeout, data line release
`timescale 1ns/1ns
module tca_link_watch #(
    parameter int TIMEOUT_C = tca_pkg::TIMEOUT_CYC
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic scl_s,      // Synchronised serial clock
    input  wire logic sda_s,      // Synchronised data line
    input  wire logic hold_req,   // Request to pull the data line low
    output logic      sda_oe,     // Data line pulled low while high
    output logic      timeout     // One-cycle pulse on a stall timeout
);

    logic        scl_q;   // Previous serial clock sample
    logic        sda_q;   // Previous data sample
    logic        busy_r;  // Inside a transaction
    logic [31:0] idle_r;  // Cycles since the last serial clock edge

    wire start_w = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_w  = scl_s & scl_q & ~sda_q & sda_s;
    wire edge_w  = scl_s ^ scl_q;
    wire to_w    = busy_r & (idle_r == 32'(TIMEOUT_C - 1));

    // ------------------------------------------------------------
    // Transaction tracking and stall counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            busy_r  <= 1'b0;
            idle_r  <= '0;
            timeout <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            scl_q   <= scl_s;
            sda_q   <= sda_s;
            busy_r  <= start_w | (busy_r & ~stop_w & ~to_w);
            idle_r  <= (start_w | edge_w | ~busy_r) ? 32'h0 : idle_r + 32'h1;
            timeout <= to_w;
            // Stalled host: let go of the line so the bus can recover
            sda_oe  <= hold_req & busy_r & ~stop_w & ~to_w;
        end
    end

    a_stall_release : assert property (@(posedge clk) disable iff (!reset_n)
        to_w |=> !sda_oe && timeout ##1 !sda_oe) else $error("line held after timeout");

endmodule // tca_link_watch

// ### tca_core.sv
// Temperature conversion and averaging core with AHB-Lite register slave
// Function
// - Stalled serial clock releases data line after timeout
// - Wait power-up interval before first conversion
// - Result reads most negative code until first
// - Start-up setting picks converting or shutdown
// - Conversion length fixed, multiplied by average count
// - Default averages eight, cycle repeats every second
// - Averaging applies to continuous and single modes
// - Last conversion of each averaging set writes the result register
// - Result is 16-bit two's complement, 7.8125 mC
// - Limits use the same signed encoding
// - Limits drive alert flags and alert pin
// - 0x0080 one degree, 0x7fff largest positive
// - Mode 00/10 continuous, 01 shutdown, 11 single
`timescale 1ns/1ns
module tca_core #(
    parameter int PWRUP_C   = tca_pkg::PWRUP_CYC,
    parameter int CONV_C    = tca_pkg::CONV_CYC,
    parameter int CYCLE_C   = tca_pkg::CYCLE_CYC,
    parameter int TIMEOUT_C = tca_pkg::TIMEOUT_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial link pins
    input  wire logic        scl_pin,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Nonvolatile start-up settings, from pins
    input  wire logic [1:0]  nv_mode,
    input  wire logic [1:0]  nv_avg,
    // Converter sample, same clock domain
    input  wire logic [15:0] raw_temp,
    // Alert pin and interrupt
    output logic             alert_pin,
    output logic             irq
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Codes 00 and 10 both mean continuous; only bit 0 is tested
    function automatic logic is_cont(input logic [1:0] m);
        return ~m[0];
    endfunction

    function automatic logic is_off(input logic [1:0] m);
        return m == tca_pkg::MODE_SHUTDOWN;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [5:0] sync_out;  // {scl, sda, nv_mode, nv_avg} after two flops
    wire        scl_s = sync_out[5];
    wire        sda_s = sync_out[4];
    tca_pkg::tca_cfg_s nv_s;  // Start-up settings as sampled

    assign nv_s = '{averaging_select: sync_out[1:0], conversion_mode_select: sync_out[3:2]};

    tca_sync #(.W(6)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({scl_pin, sda_in, nv_mode, nv_avg}),
        .q       (sync_out)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    tca_pkg::tca_state_e  state_r, state_nxt;  // Sequencer state
    tca_pkg::tca_cfg_s    cfg_r, cfg_nxt;      // Mode and averaging
    logic [31:0]          cnt_r;               // Cycles in the current step
    logic [31:0]          cyc_r;               // Cycles since cycle start
    logic [2:0]           smp_r;               // Samples taken this result
    logic signed [18:0]   acc_r;               // Sample accumulator
    logic [15:0]          result_r;            // temperature_result
    logic [15:0]          upper_r;             // upper_threshold
    logic [15:0]          lower_r;             // lower_threshold
    logic [tca_pkg::ST_W-1:0] status_r;        // Sticky event bits
    logic [tca_pkg::ST_W-1:0] enable_r;        // Interrupt enables
    logic                 hold_r;              // Link drive request
    logic                 dp_wr_r;             // Write data phase pending
    logic [7:0]           dp_addr_r;           // Data phase address
    logic                 link_to;             // Bus stall timeout pulse

    // ------------------------------------------------------------
    // AHB-Lite decode
    // ------------------------------------------------------------
    // Zero wait states: read data is latched at the address phase edge
    wire       addr_take = hsel & htrans[1] & hready;
    wire       wr_take   = addr_take & hwrite & (hsize == tca_pkg::HSIZE_WORD);
    wire [7:0] ra        = haddr[7:0];
    wire       wr_upper  = dp_wr_r & (dp_addr_r == tca_pkg::OFF_UPPER);
    wire       wr_lower  = dp_wr_r & (dp_addr_r == tca_pkg::OFF_LOWER);
    wire       wr_config = dp_wr_r & (dp_addr_r == tca_pkg::OFF_CONFIG);
    wire       wr_clear  = dp_wr_r & (dp_addr_r == tca_pkg::OFF_CLEAR);
    wire       wr_enable = dp_wr_r & (dp_addr_r == tca_pkg::OFF_ENABLE);
    wire       wr_link   = dp_wr_r & (dp_addr_r == tca_pkg::OFF_LINK);

    // Unmapped and write-only offsets read as zero
    wire [31:0] rd_mux =
        (ra == tca_pkg::OFF_RESULT) ? {16'h0, result_r} :
        (ra == tca_pkg::OFF_UPPER)  ? {16'h0, upper_r}  :
        (ra == tca_pkg::OFF_LOWER)  ? {16'h0, lower_r}  :
        (ra == tca_pkg::OFF_CONFIG) ? {28'h0, cfg_r}    :
        (ra == tca_pkg::OFF_STATUS) ? {28'h0, status_r} :
        (ra == tca_pkg::OFF_ENABLE) ? {28'h0, enable_r} :
        (ra == tca_pkg::OFF_LINK)   ? {31'h0, hold_r}   : 32'h0;

    // ------------------------------------------------------------
    // Conversion datapath
    // ------------------------------------------------------------
    wire        avg8      = cfg_r.averaging_select == tca_pkg::AVG_EIGHT;
    wire [2:0]  smp_last  = avg8 ? tca_pkg::AVG_LAST_EIGHT : tca_pkg::AVG_LAST_ONE;
    wire        in_conv   = state_r == tca_pkg::TCA_CONVERT;
    wire        conv_end  = in_conv & (cnt_r == 32'(CONV_C - 1));
    // >= so a mid-run drop from eight to one still publishes
    wire        publish   = conv_end & (smp_r >= smp_last);
    wire signed [18:0] sum_w = acc_r + 19'(signed'(raw_temp));
    // Arithmetic shift floors toward minus infinity
    wire [15:0] mean_w    = avg8 ? sum_w[18:3] : sum_w[15:0];
    wire        hi_w      = $signed(mean_w) > $signed(upper_r);
    wire        lo_w      = $signed(mean_w) < $signed(lower_r);
    wire        pwr_done  = (state_r == tca_pkg::TCA_POWERUP) & (cnt_r == 32'(PWRUP_C - 1));
    wire        cyc_done  = cyc_r >= 32'(CYCLE_C - 1);
    wire        mode_off  = is_off(cfg_r.conversion_mode_select);
    wire        mode_one  = cfg_r.conversion_mode_select == tca_pkg::MODE_SINGLE;

    wire [tca_pkg::ST_W-1:0] ev_set = {link_to, publish & lo_w, publish & hi_w, publish};
    wire [tca_pkg::ST_W-1:0] ev_clr = wr_clear ? hwdata[tca_pkg::ST_W-1:0] : '0;

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            tca_pkg::TCA_POWERUP: begin
                // Nothing converts before the power-up wait has run out
                if (pwr_done) begin
                    state_nxt = is_cont(nv_s.conversion_mode_select) ?
                                tca_pkg::TCA_CONVERT : tca_pkg::TCA_POWER_DOWN;
                end
            end
            tca_pkg::TCA_CONVERT: begin
                if (mode_off) begin
                    state_nxt = tca_pkg::TCA_POWER_DOWN;
                end else if (publish) begin
                    state_nxt = mode_one ? tca_pkg::TCA_POWER_DOWN : tca_pkg::TCA_STANDBY;
                end
            end
            tca_pkg::TCA_STANDBY: begin
                if (mode_off) begin
                    state_nxt = tca_pkg::TCA_POWER_DOWN;
                end else if (cyc_done || mode_one) begin
                    state_nxt = tca_pkg::TCA_CONVERT;
                end
            end
            tca_pkg::TCA_POWER_DOWN: begin
                if (!mode_off) begin
                    state_nxt = tca_pkg::TCA_CONVERT;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Configuration next value
    // ------------------------------------------------------------
    // Start-up load first, then software, then single-shot completion
    always_comb begin
        cfg_nxt = cfg_r;
        if (pwr_done) begin
            cfg_nxt = nv_s;
            if (!is_cont(nv_s.conversion_mode_select)) begin
                // Single mode is not a legal start-up mode
                cfg_nxt.conversion_mode_select = tca_pkg::MODE_SHUTDOWN;
            end
        end else if (wr_config) begin
            cfg_nxt = hwdata[3:0];
        end else if (publish && mode_one) begin
            cfg_nxt.conversion_mode_select = tca_pkg::MODE_SHUTDOWN;
        end
    end

    // ------------------------------------------------------------
    // Sequencer and counters
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= tca_pkg::TCA_POWERUP;
            cnt_r   <= '0;
            cyc_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= (state_nxt != state_r || conv_end) ? 32'h0 : cnt_r + 32'h1;
            cyc_r   <= (state_nxt == tca_pkg::TCA_CONVERT && !in_conv) ? 32'h0 : cyc_r + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Averaging accumulator
    // ------------------------------------------------------------
    // An abort restarts the set, so no stale samples leak into a mean
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            smp_r <= '0;
            acc_r <= '0;
        end else if (!in_conv || publish) begin
            smp_r <= '0;
            acc_r <= '0;
        end else if (conv_end) begin
            smp_r <= smp_r + 3'h1;
            acc_r <= sum_w;
        end
    end

    // ------------------------------------------------------------
    // Result, limits and configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result_r <= tca_pkg::RESULT_RESET;
            upper_r  <= tca_pkg::UPPER_RESET;
            lower_r  <= tca_pkg::LOWER_RESET;
            cfg_r    <= tca_pkg::CFG_RESET;
            hold_r   <= 1'b0;
        end else begin
            // One 16-bit store, so a read never sees halves of two results
            if (publish) begin
                result_r <= mean_w;
            end
            if (wr_upper) begin
                upper_r <= hwdata[15:0];
            end
            if (wr_lower) begin
                lower_r <= hwdata[15:0];
            end
            if (wr_link) begin
                hold_r <= hwdata[0];
            end
            cfg_r <= cfg_nxt;
        end
    end

    // ------------------------------------------------------------
    // Events, interrupt and alert pin
    // ------------------------------------------------------------
    // A new event in the cycle of its clear stays set
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_r  <= tca_pkg::STATUS_RESET;
            enable_r  <= tca_pkg::STATUS_RESET;
            irq       <= 1'b0;
            alert_pin <= 1'b0;
        end else begin
            status_r  <= (status_r & ~ev_clr) | ev_set;
            enable_r  <= wr_enable ? hwdata[tca_pkg::ST_W-1:0] : enable_r;
            irq       <= |(status_r & enable_r);
            alert_pin <= status_r[tca_pkg::ST_HIGH] | status_r[tca_pkg::ST_LOW];
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite data phase
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            sda_out   <= 1'b0;
        end else begin
            dp_wr_r   <= wr_take;
            dp_addr_r <= addr_take ? ra : dp_addr_r;
            hrdata    <= (addr_take && !hwrite) ? rd_mux : hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            sda_out   <= 1'b0;  // Open drain: only ever pulls low
        end
    end

    // ------------------------------------------------------------
    // Serial link watcher
    // ------------------------------------------------------------
    tca_link_watch #(.TIMEOUT_C(TIMEOUT_C)) u_link (
        .clk      (clk),
        .reset_n  (reset_n),
        .scl_s    (scl_s),
        .sda_s    (sda_s),
        .hold_req (hold_r),
        .sda_oe   (sda_oe),
        .timeout  (link_to)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_powerup_quiet : assert property (
        state_r == tca_pkg::TCA_POWERUP |-> !conv_end && !publish)
        else $error("conversion during power-up");
    a_result_initial : assert property (
        state_r == tca_pkg::TCA_POWERUP |-> result_r == 16'h8000)
        else $error("result not at initial code");
    a_startup_mode : assert property (
        pwr_done && !nv_s.conversion_mode_select[0] |=> state_r == tca_pkg::TCA_CONVERT)
        else $error("start-up mode ignored");
    a_mean_eight : assert property (
        publish && avg8 |-> smp_r == 3'h7 ##1 result_r == $past(sum_w[18:3]))
        else $error("mean of eight wrong");
    a_conv_length : assert property (
        in_conv && !mode_off && cnt_r != 32'(CONV_C - 1) |=> in_conv)
        else $error("conversion too short");
    a_result_update : assert property (
        publish |=> result_r == $past(mean_w) && status_r[tca_pkg::ST_READY])
        else $error("result not written");
    a_high_flag : assert property (
        publish && hi_w |=> status_r[tca_pkg::ST_HIGH] ##1 alert_pin)
        else $error("high limit flag missing");
    a_shutdown_abort : assert property (
        mode_off && (in_conv || state_r == tca_pkg::TCA_STANDBY)
        |=> state_r == tca_pkg::TCA_POWER_DOWN)
        else $error("shutdown did not abort");
    a_single_end : assert property (
        publish && mode_one && !wr_config |=> cfg_r.conversion_mode_select == 2'h1
        && state_r == tca_pkg::TCA_POWER_DOWN)
        else $error("single conversion not followed by shutdown");
    a_result_steady : assert property (
        !publish |=> $stable(result_r))
        else $error("result changed without conversion");

endmodule // tca_core

// ### tca_host_model.sv
// Behavioural two-wire bus host facing the core's serial pins
`timescale 1ns/1ns
module tca_host_model (
    input  wire logic sda_oe,   // Core pulls the data line low
    output logic      scl,      // Serial clock, idle high
    output logic      sda_line  // Resolved data line level
);
    logic host_sda = 1'b1;      // Host side of the open-drain data line
    // Pull-up wins unless a party pulls low
    assign sda_line = host_sda & ~sda_oe;
    // Clock stands still high outside frames
    initial scl = 1'b1;
    // Start: data falls while the clock is high, kept off the system clock edge
    task automatic start();
        #5 host_sda = 1'b0;
        #80 scl = 1'b0;
    endtask
    // Clock pulses at a 160 ns period, then the clock rests low
    task automatic clocks(input int n);
        repeat (n) begin
            #80 scl = 1'b1;
            #80 scl = 1'b0;
        end
    endtask
    // Stop: data rises while the clock is high
    task automatic stop();
        #80 scl = 1'b1;
        #80 host_sda = 1'b1;
    endtask
endmodule // tca_host_model

// ### temperature_conversion_averaging_core_tb_top.sv
// Testbench: register bus, conversions, averaging, alerts and link timeout
`timescale 1ns/1ns
module temperature_conversion_averaging_core_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk = 0, reset_n = 0, hsel = 0, hwrite = 0;
    logic [2:0]  hsize = 3'h2;
    logic [1:0]  htrans = 2'h0, nv_mode = 2'h0, nv_avg = 2'h1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [15:0] raw_temp = 16'hf380;  // Negative sample, checks signed mean
    logic        hreadyout, hresp, scl, sda, sda_out, sda_oe, alert_pin, irq;
    int          err_count = 0, n_checks = 0, cyc = 0;
    always #10 clk = ~clk;
    // Counts shortened so the whole run stays small
    tca_core #(.PWRUP_C(20), .CONV_C(10), .CYCLE_C(200), .TIMEOUT_C(50)) i_dut (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_pin(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .nv_mode(nv_mode),
        .nv_avg(nv_avg), .raw_temp(raw_temp), .alert_pin(alert_pin), .irq(irq));
    tca_host_model i_host (.sda_oe(sda_oe), .scl(scl), .sda_line(sda));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out();
        if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One single AHB transfer; read data taken at the data-phase edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Poll the ready flag; the cycle ceiling ends a hang
    task automatic wait_ready();
        do acc(1'b0, tca_pkg::OFF_STATUS, 32'h0); while (q[0] !== 1'b1);
    endtask
    // Cycle ceiling, well above the expected run of some 700 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd(tca_pkg::OFF_RESULT, 32'h8000);
        rd(tca_pkg::OFF_UPPER, 32'h7fff);
        repeat (50) @(posedge clk);
        rd(tca_pkg::OFF_STATUS, 32'h0);
        rd(tca_pkg::OFF_CONFIG, 32'h4);
        wait_ready();
        rd(tca_pkg::OFF_RESULT, 32'hf380);
        acc(1'b1, tca_pkg::OFF_CONFIG, 32'h5);
        acc(1'b1, tca_pkg::OFF_CLEAR, 32'hf);
        repeat (250) @(posedge clk);
        rd(tca_pkg::OFF_STATUS, 32'h0);
        // Negative upper limit: only a signed compare flags 0x0080 as high
        acc(1'b1, tca_pkg::OFF_UPPER, 32'hff00);
        // A byte-sized write must leave the word untouched
        hsize <= 3'h0;
        acc(1'b1, tca_pkg::OFF_UPPER, 32'h1234);
        hsize <= 3'h2;
        rd(tca_pkg::OFF_UPPER, 32'hff00);
        acc(1'b1, tca_pkg::OFF_ENABLE, 32'h2);
        raw_temp <= 16'h0080;
        acc(1'b1, tca_pkg::OFF_CONFIG, 32'h3);
        wait_ready();
        rd(tca_pkg::OFF_RESULT, 32'h0080);
        rd(tca_pkg::OFF_STATUS, 32'h3);
        chk({28'h0, hresp, sda_out, irq, alert_pin}, 32'h3);
        rd(tca_pkg::OFF_CONFIG, 32'h1);
        acc(1'b1, tca_pkg::OFF_CLEAR, 32'hf);
        raw_temp <= 16'h7fff;
        acc(1'b1, tca_pkg::OFF_CONFIG, 32'h7);
        repeat (40) @(posedge clk);
        rd(tca_pkg::OFF_STATUS, 32'h0);
        wait_ready();
        rd(tca_pkg::OFF_RESULT, 32'h7fff);
        // Link: hold data low in a frame, then stall the clock
        acc(1'b1, tca_pkg::OFF_LINK, 32'h1);
        i_host.start();
        i_host.clocks(2);
        repeat (5) @(posedge clk);
        chk(sda_oe, 32'h1);
        repeat (70) @(posedge clk);
        chk(sda_oe, 32'h0);
        rd(tca_pkg::OFF_STATUS, 32'hb);
        i_host.stop();
        // Second reset with a single-shot start-up setting: starts shut down
        nv_mode <= 2'h3;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (30) @(posedge clk);
        rd(tca_pkg::OFF_CONFIG, 32'h5);
        rd(tca_pkg::OFF_RESULT, 32'h8000);
        close_out();
    end
endmodule // temperature_conversion_averaging_core_tb_top
